// ---- hw/video_sync_params.svh ----
// Contract
// - hsync driven when generator on, else input
// - vsync driven when generator on, else input
// - shared pin: field flag or line phase
// - field flag high on odd fields
// - line phase: master clock divided, line period
// - shared pin: blanking or subcarrier select
// - subcarrier is master clock over 8/16
// - composite sync always output from dot clock
// - low sync reset restarts generator
// - divided clock output ratio 1,2,4,8
// - dot clock 13.5 MHz, in or made; the made one runs at 250 MHz over 18, 13.9 MHz
`ifndef VIDEO_SYNC_PARAMS_SVH
`define VIDEO_SYNC_PARAMS_SVH
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_LINE 4'h2
`define REG_PIXEL 4'h3
`define CTRL_GEN_ON 0
`define CTRL_FIELD_MODE 1
`define CTRL_BLANK_MODE 2
`define CTRL_FSC_DIV16 3
`define CTRL_CLKDIV_LO 4
`define CTRL_CLKDIV_HI 5
`define CTRL_DOT_INT 6
`define CTRL_RESET 8'h01
`define DOT_DIV 10'd18
`define DOT_HALF 10'd9
`define PIX_TOTAL 11'd858
`define PIX_ACTIVE 11'd720
`define HSYNC_W 11'd64
`define LINE_TOTAL 10'd525
`define LINE_HALF 10'd263
`define VSYNC_LINES 10'd3
`define VBLANK_LINES 10'd20
`define FSC_BITS 5
`define HREF_DIV 14'd1820
`endif

// ---- hw/video_sync_pkg.sv ----
package video_sync_pkg;
    typedef logic [1:0] clk_div_type;
endpackage

// ---- hw/video_sync_timing_pins.sv ----
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "video_sync_params.svh"

// ==========================================================
// one registered pin: level and active-low drive enable
module pin_stage
#(
    parameter logic OUT_RST = 1'b1
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic val,
    input wire logic drive,
    output logic pin_out,
    output logic pin_oe_n
);

// released pins idle with oe_n high so nothing fights the far side
always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        pin_out <= OUT_RST;
        pin_oe_n <= 1'b1;
    end
    else
    begin
        pin_out <= val;
        pin_oe_n <= !drive;
    end
end

endmodule

module video_sync_timing_pins
    import video_sync_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic video_master_clock,
    input wire logic pixel_dot_clock_in,
    output logic pixel_dot_clock_out,
    output logic pixel_dot_clock_oe_n,
    input wire logic hsync_in,
    output logic hsync_out,
    output logic hsync_oe_n,
    input wire logic vsync_in,
    output logic vsync_out,
    output logic vsync_oe_n,
    input wire logic field_pin_in,
    output logic field_pin_out,
    output logic field_pin_oe_n,
    input wire logic blank_pin_in,
    output logic blank_pin_out,
    output logic blank_pin_oe_n,
    output logic composite_sync_out,
    input wire logic sync_gen_reset_n,
    output logic divided_video_clock_out
);

// ==========================================================
// registers
logic [7:0] ctrl_ff;
logic [7:0] rdata_ff;

// control fields, decoded once so the rest reads by name
wire gen_on = ctrl_ff[`CTRL_GEN_ON];
wire field_mode = ctrl_ff[`CTRL_FIELD_MODE];
wire blank_mode = ctrl_ff[`CTRL_BLANK_MODE];
wire fsc_div16 = ctrl_ff[`CTRL_FSC_DIV16];
wire dot_int = ctrl_ff[`CTRL_DOT_INT];
clk_div_type clk_div_sel;
assign clk_div_sel = ctrl_ff[`CTRL_CLKDIV_HI:`CTRL_CLKDIV_LO];

// only the control register takes writes; other indices drop them
wire ctrl_wr = wr_stb && (addr == `REG_CTRL);

always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
        ctrl_ff <= `CTRL_RESET;
    else if (ctrl_wr)
        ctrl_ff <= wdata;
end

// ==========================================================
// master and dot clock edge detect; inputs are taken as synchronous
logic mclk_d_ff;
logic pixel_dot_clock_d_ff;

always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        mclk_d_ff <= 1'b0;
        pixel_dot_clock_d_ff <= 1'b0;
    end
    else
    begin
        mclk_d_ff <= video_master_clock;
        pixel_dot_clock_d_ff <= pixel_dot_clock_in;
    end
end

// one-cycle pulse on each master clock rise
wire mclk_rise = video_master_clock && !mclk_d_ff;

// ==========================================================
// dot clock: made by dividing clk_sys, or taken from the pin
logic [9:0] dot_cnt_ff;
logic dot_gen_ff;

wire dot_wrap = (dot_cnt_ff == `DOT_DIV - 10'd1);
wire [9:0] nxt_dot_cnt = dot_wrap ? 10'd0 : dot_cnt_ff + 10'd1;
wire nxt_dot_gen = (nxt_dot_cnt < `DOT_HALF);

always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        dot_cnt_ff <= 10'd0;
        dot_gen_ff <= 1'b1;
    end
    else
    begin
        dot_cnt_ff <= nxt_dot_cnt;
        dot_gen_ff <= nxt_dot_gen;
    end
end

// 250 MHz over 18 gives 13.9 MHz; exact 13.5 needs an external dot clock
wire dot_tick = dot_int ? dot_wrap : (pixel_dot_clock_in && !pixel_dot_clock_d_ff);

// ==========================================================
// shared pixel and line counters
logic [10:0] pix_ff;
logic [9:0] line_ff;
logic odd_ff;
logic sgr_n_ff;

wire pix_wrap = (pix_ff == `PIX_TOTAL - 11'd1);
wire line_wrap = (line_ff == `LINE_TOTAL - 10'd1);
wire [10:0] nxt_pix = pix_wrap ? 11'd0 : pix_ff + 11'd1;
wire [9:0] nxt_line = line_wrap ? 10'd0 : line_ff + 10'd1;
wire half_point = pix_wrap && (line_ff == `LINE_HALF - 10'd1);

// restart pin passes one flop, so a restart shows two cycles late
always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
        sgr_n_ff <= 1'b1;
    else
        sgr_n_ff <= sync_gen_reset_n;
end

// field turns even at mid-frame and odd again at frame end
always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        pix_ff <= 11'd0;
        line_ff <= 10'd0;
        odd_ff <= 1'b1;
    end
    else if (!sgr_n_ff)
    begin
        pix_ff <= 11'd0;
        line_ff <= 10'd0;
        odd_ff <= 1'b1;
    end
    else if (dot_tick)
    begin
        pix_ff <= nxt_pix;
        if (pix_wrap)
            line_ff <= nxt_line;
        if (half_point)
            odd_ff <= 1'b0;
        else if (pix_wrap && line_wrap)
            odd_ff <= 1'b1;
    end
end

// field-relative line so both fields get their vsync
wire [9:0] fline = odd_ff ? line_ff : line_ff - (`LINE_HALF - 10'd1);

wire hs_act = (pix_ff < `HSYNC_W);
wire vs_act = (fline < `VSYNC_LINES);
wire blank_act = (pix_ff >= `PIX_ACTIVE) || (fline < `VBLANK_LINES);

// ==========================================================
// master clock dividers
logic [`FSC_BITS-1:0] fsc_cnt_ff;
logic [2:0] cdiv_cnt_ff;
logic [13:0] href_cnt_ff;
logic href_ff;

wire href_wrap = (href_cnt_ff == `HREF_DIV - 14'd1);

// line phase is high for the first half of each period
always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        fsc_cnt_ff <= '0;
        cdiv_cnt_ff <= 3'h0;
        href_cnt_ff <= 14'h0000;
        href_ff <= 1'b0;
    end
    else if (mclk_rise)
    begin
        fsc_cnt_ff <= fsc_cnt_ff + 1'b1;
        cdiv_cnt_ff <= cdiv_cnt_ff + 3'h1;
        href_cnt_ff <= href_wrap ? 14'h0000 : href_cnt_ff + 14'h0001;
        if (href_wrap)
            href_ff <= 1'b1;
        else if (href_cnt_ff == (`HREF_DIV >> 1) - 14'd1)
            href_ff <= 1'b0;
    end
end

// counters step on master clock rise; sampling limits ratio 1 to clk_sys/2
wire fsc_bit = fsc_div16 ? fsc_cnt_ff[3] : fsc_cnt_ff[2];

logic cdiv_bit;
always_comb
begin
    case (clk_div_sel)
        2'h0: cdiv_bit = video_master_clock;
        2'h1: cdiv_bit = cdiv_cnt_ff[0];
        2'h2: cdiv_bit = cdiv_cnt_ff[1];
        2'h3: cdiv_bit = cdiv_cnt_ff[2];
        default: cdiv_bit = 1'b0;
    endcase
end

// ==========================================================
// pin drivers, all registered
wire field_drive = field_mode || gen_on;
wire blank_drive = blank_mode || gen_on;
wire field_val = field_mode ? href_ff : odd_ff;
wire blank_val = blank_mode ? fsc_bit : !blank_act;

// each two-way sync pin (hsync, vsync, field, blank) gets a registered level and enable stage; field resets its level low, the rest high
pin_stage #(.OUT_RST(1'b1)) hsync_stage (
    .clk_sys(clk_sys),
    .rst(rst),
    .val(!hs_act),
    .drive(gen_on),
    .pin_out(hsync_out),
    .pin_oe_n(hsync_oe_n)
);

pin_stage #(.OUT_RST(1'b1)) vsync_stage (
    .clk_sys(clk_sys),
    .rst(rst),
    .val(!vs_act),
    .drive(gen_on),
    .pin_out(vsync_out),
    .pin_oe_n(vsync_oe_n)
);

pin_stage #(.OUT_RST(1'b0)) field_stage (
    .clk_sys(clk_sys),
    .rst(rst),
    .val(field_val),
    .drive(field_drive),
    .pin_out(field_pin_out),
    .pin_oe_n(field_pin_oe_n)
);

pin_stage #(.OUT_RST(1'b1)) blank_stage (
    .clk_sys(clk_sys),
    .rst(rst),
    .val(blank_val),
    .drive(blank_drive),
    .pin_out(blank_pin_out),
    .pin_oe_n(blank_pin_oe_n)
);

// output-only pins and the dot clock pin
always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
    begin
        composite_sync_out <= 1'b1;
        divided_video_clock_out <= 1'b0;
        pixel_dot_clock_out <= 1'b0;
        pixel_dot_clock_oe_n <= 1'b1;
    end
    else
    begin
        composite_sync_out <= !(hs_act ^ vs_act);
        divided_video_clock_out <= cdiv_bit;
        pixel_dot_clock_out <= dot_gen_ff;
        pixel_dot_clock_oe_n <= !dot_int;
    end
end

// ==========================================================
// read back
wire [7:0] status_val = {3'h0, blank_pin_in, field_pin_in, vsync_in,
    hsync_in, odd_ff};

logic [7:0] nxt_rdata;
always_comb
begin
    case (addr)
        `REG_CTRL: nxt_rdata = ctrl_ff;
        `REG_STATUS: nxt_rdata = status_val;
        `REG_LINE: nxt_rdata = line_ff[9:2];
        `REG_PIXEL: nxt_rdata = pix_ff[10:3];
        default: nxt_rdata = 8'h00;
    endcase
end

// read data stand one cycle only and are zero otherwise
always_ff @(posedge clk_sys or posedge rst)
begin
    if (rst)
        rdata_ff <= 8'h00;
    else
        rdata_ff <= rd_stb ? nxt_rdata : 8'h00;
end

assign rdata = rdata_ff;

endmodule
`default_nettype wire

// ---- verif/video_sync_timing_pins_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========
// pin direction, idle read data and restart field checks
module video_sync_timing_pins_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic sync_gen_reset_n,
    input wire logic hsync_oe_n,
    input wire logic vsync_oe_n,
    input wire logic field_pin_oe_n,
    input wire logic blank_pin_oe_n,
    input wire logic field_pin_out
);
    logic [7:0] ctrl_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            ctrl_ff <= 8'h01;
        else if (wr_stb && addr == 4'h0)
            ctrl_ff <= wdata;
    // three quiet cycles cover register and pin flop lag
    sequence calm;
        $stable(ctrl_ff)[*3];
    endsequence
    gen_off_a: assert property (
        calm ##0 !ctrl_ff[0] |-> hsync_oe_n && vsync_oe_n)
        else $error("sync driven while off");
    gen_on_a: assert property (
        calm ##0 ctrl_ff[0] |-> !hsync_oe_n && !vsync_oe_n)
        else $error("sync not driven while on");
    field_dir_a: assert property (
        calm ##0 !ctrl_ff[1] |-> field_pin_oe_n == !ctrl_ff[0])
        else $error("field pin direction");
    phase_drive_a: assert property (
        calm ##0 ctrl_ff[1] |-> !field_pin_oe_n)
        else $error("line phase not driven");
    blank_dir_a: assert property (
        calm ##0 !ctrl_ff[2] |-> blank_pin_oe_n == !ctrl_ff[0])
        else $error("blank pin direction");
    fsc_drive_a: assert property (
        calm ##0 ctrl_ff[2] |-> !blank_pin_oe_n)
        else $error("subcarrier not driven");
    read_idle_a: assert property (
        !rd_stb |=> rdata == 8'h00)
        else $error("read data without read");
    odd_reset_a: assert property (
        (!sync_gen_reset_n && $stable(ctrl_ff))[*4]
        ##0 ctrl_ff[1:0] == 2'b01 |-> field_pin_out)
        else $error("field not odd after restart");
endmodule
bind video_sync_timing_pins video_sync_timing_pins_assertions chk (.*);
`default_nettype wire

// ---- verif/video_side_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========
// encoder side
module video_side_model (
    input wire logic [3:0] lvl,
    input wire logic [3:0] dut_out,
    input wire logic [3:0] dut_oe_n,
    output logic [3:0] pin,
    output logic master_clk,
    output logic dot_clk
);
    // odd edge times keep both clocks off the sampling edge
    initial
    begin
        master_clk = 1'b0;
        dot_clk = 1'b0;
        #1;
        fork
            forever #8 master_clk = ~master_clk;
            forever #37.037 dot_clk = ~dot_clk;
        join
    end
    // drive a sync line only while the decoder lets go
    assign pin = (dut_oe_n & lvl) | (~dut_oe_n & dut_out);
endmodule
`default_nettype wire

// ---- verif/video_sync_timing_pins_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "video_sync_params.svh"
// ========
// register and pin timing
module video_sync_timing_pins_test;
    logic clk_sys, rst, wr_stb, rd_stb, sync_gen_reset_n;
    logic [3:0] addr, lvl;
    logic [7:0] wdata, got;
    wire [7:0] rdata;
    wire video_master_clock, pixel_dot_clock_in, pixel_dot_clock_out;
    wire pixel_dot_clock_oe_n, composite_sync_out, divided_video_clock_out;
    wire hsync_in, hsync_out, hsync_oe_n, vsync_in, vsync_out, vsync_oe_n;
    wire field_pin_in, field_pin_out, field_pin_oe_n;
    wire blank_pin_in, blank_pin_out, blank_pin_oe_n;
    wire [5:0] mon = {pixel_dot_clock_out, composite_sync_out, hsync_out,
        divided_video_clock_out, blank_pin_out, field_pin_out};
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    video_sync_timing_pins uut (.*);
    video_side_model far (
        .lvl(lvl),
        .dut_out({blank_pin_out, field_pin_out, vsync_out, hsync_out}),
        .dut_oe_n({blank_pin_oe_n, field_pin_oe_n, vsync_oe_n, hsync_oe_n}),
        .pin({blank_pin_in, field_pin_in, vsync_in, hsync_in}),
        .master_clk(video_master_clock),
        .dot_clk(pixel_dot_clock_in)
    );
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (++cyc == 100000)
        begin
            miscompares++;
            wrap_up;
        end
    task automatic wrap_up;
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %0h got %0h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 got = rdata;
    endtask
    // second to third rising edge, so a ratio change has settled
    task automatic period(input int s, input int e, input string nm);
        int n;
        int r;
        int g;
        logic p;
        n = 0;
        r = 0;
        g = 0;
        p = mon[s];
        while (r < 3 && g < 50000)
        begin
            @(posedge clk_sys);
            #1;
            g++;
            if (r == 2)
                n++;
            if (mon[s] && !p)
                r++;
            p = mon[s];
        end
        cmp(nm, e, n);
    endtask
    initial
    begin
        rst = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        sync_gen_reset_n = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        lvl = 4'hA;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rd(4'h0);
        cmp("ctrl", 8'h01, got);
        wr(4'h9, 8'hFF);
        rd(4'h9);
        cmp("unmapped", 8'h00, got);
        cmp("dot_oe", 1'b1, pixel_dot_clock_oe_n);
        wr(4'h0, 8'h00);
        repeat (4) @(posedge clk_sys);
        rd(4'h1);
        cmp("status", 8'h14, got & 8'hFE);
        wr(4'h0, 8'h41);
        sync_gen_reset_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rd(4'h1);
        cmp("odd", 1'b1, got[0]);
        cmp("vsync_rst", 1'b0, vsync_out);
        cmp("hsync_rst", 1'b0, hsync_out);
        sync_gen_reset_n <= 1'b1;
        // about 100 internal dot ticks into line 0: vsync on, hsync off
        repeat (100 * `DOT_DIV) @(posedge clk_sys);
        #1;
        cmp("hsync_mid", 1'b1, hsync_out);
        cmp("vsync_mid", 1'b0, vsync_out);
        cmp("composite_sync_out_mid", 1'b0, composite_sync_out);
        rd(4'h3);
        cmp("pixel", 8'h0C, got);
        for (int k = 0; k < 4; k++)
        begin
            wr(4'h0, 8'h01 | 8'(k << 4));
            period(2, 4 << k, "divclk");
        end
        wr(4'h0, 8'h05);
        period(1, 32, "fsc8");
        wr(4'h0, 8'h0D);
        period(1, 64, "fsc16");
        wr(4'h0, 8'h03);
        period(0, 4 * `HREF_DIV, "lineref");
        wr(4'h0, 8'h41);
        period(3, int'(`PIX_TOTAL) * `DOT_DIV, "hsync");
        period(5, `DOT_DIV, "dotclk");
        cmp("dot_oe", 1'b0, pixel_dot_clock_oe_n);
        wrap_up;
    end
endmodule
`default_nettype wire
